// file: rtl/ncm_pkg.sv
// shared constants and types for the nco mixer, pn and cic front end
package ncm_pkg;
   // register byte offsets on the axi4-lite port
   localparam logic [7:0] ADDR_FREQ_HOLD = 8'h00;
   localparam logic [7:0] ADDR_FREQ_XFER = 8'h04;
   localparam logic [7:0] ADDR_PHASE_OFS = 8'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_PN_SCALE = 8'h10;
   localparam logic [7:0] ADDR_DECIM = 8'h14;
   localparam logic [7:0] ADDR_FREQ_ACT = 8'h18;
   localparam logic [7:0] ADDR_PHASE_RD = 8'h1C;
   // control register fields
   localparam int CTRL_ORDER_LSB = 0;
   localparam int CTRL_SYNC_EN = 4;
   localparam int CTRL_ZERO_EN = 5;
   localparam int CTRL_BYPASS = 15;
   localparam int CTRL_SHIFT_LSB = 20;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] FREQ_RST = 32'h0000_0000;
   localparam logic [31:0] PHASE_OFS_RST = 32'h0000_0000;
   localparam logic [15:0] PN_SCALE_RST = 16'h0000;
   localparam logic [15:0] DECIM_RST = 16'h0000;
   localparam logic [22:0] LFSR_SEED = 23'h7FFFFF;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // datapath widths
   localparam int PHASE_W = 24;
   localparam int AMP_W = 19;
   localparam int MIX_W = 24;
   localparam int PATH_W = 69;
   localparam int NSTG = 5;
   localparam int CORDIC_N = 16;
   localparam int CORDIC_W = 22;
   localparam int SHIFT_MAX = 47;
   localparam int PN_LSB = 5;
   // cordic start magnitude, kept a little under full scale over the cordic gain
   // so that growth and rounding cannot wrap the 19-bit sinusoid at its peak
   localparam logic signed [21:0] CORDIC_X0 = 22'sh026D05;
   typedef struct packed {
      logic signed [15:0] mant;
      logic [3:0] expo;
   } ncm_smp_t;
   typedef struct packed {
      logic signed [23:0] i;
      logic signed [23:0] q;
   } ncm_iq_t;
   function automatic int ncm_integ_w(input int k);
      case (k)
         0: return 69;
         1: return 62;
         2: return 53;
         3: return 44;
         default: return 34;
      endcase
   endfunction
   // arctangent of 2^-i in units of 2^-24 of a turn
   function automatic logic [23:0] ncm_atan(input int i);
      case (i)
         0: return 24'h200000;
         1: return 24'h12E405;
         2: return 24'h09FB38;
         3: return 24'h05110A;
         4: return 24'h028B0D;
         default: return 24'(2670177 >> i);
      endcase
   endfunction
endpackage

// file: rtl/ncm_top.sv
// nco, mixer, pn injection, barrel shifter and cic decimator for one channel
`timescale 1ns/100ps
`default_nettype none
module ncm_top
   import ncm_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire ncm_smp_t in_sample,
   input wire logic input_enable_n,
   input wire logic sync_pulse_input,
   output ncm_iq_t out_data,
   output logic out_valid
);
   logic [31:0] freq_hold_r, freq_act_r, phase_ofs_r, ctrl_r, phase_acc_r;
   logic [15:0] pn_scale_r, decim_r;
   logic aw_have_r, w_have_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_go, xfer_wr, load_ev, accept;
   logic [2:0] sync_sh_r;
   logic sync_lvl_r, sync_ev;

   // ---------------- axi4-lite slave ----------------
   assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready = !w_have_r && !s_axi_bvalid;
   assign wr_go = aw_have_r && w_have_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_have_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_go) begin
            w_have_r <= 1'b0;
         end
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) r[8*b +: 8] = d[8*b +: 8];
      end
      return r;
   endfunction

   function automatic logic known(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= ADDR_PHASE_RD;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= known(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         freq_hold_r <= FREQ_RST;
         phase_ofs_r <= PHASE_OFS_RST;
         ctrl_r <= CTRL_RST;
         pn_scale_r <= PN_SCALE_RST;
         decim_r <= DECIM_RST;
      end else if (wr_go) begin
         case (aw_addr_r)
            ADDR_FREQ_HOLD: freq_hold_r <= merge(freq_hold_r, w_data_r, w_strb_r);
            ADDR_PHASE_OFS: phase_ofs_r <= merge(phase_ofs_r, w_data_r, w_strb_r);
            ADDR_CTRL: ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r);
            ADDR_PN_SCALE: pn_scale_r <= 16'(merge({16'h0000, pn_scale_r}, w_data_r, w_strb_r));
            ADDR_DECIM: decim_r <= 16'(merge({16'h0000, decim_r}, w_data_r, w_strb_r));
            default: ;
         endcase
      end
   end

   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            ADDR_FREQ_HOLD: s_axi_rdata <= freq_hold_r;
            ADDR_PHASE_OFS: s_axi_rdata <= phase_ofs_r;
            ADDR_CTRL: s_axi_rdata <= ctrl_r;
            ADDR_PN_SCALE: s_axi_rdata <= {16'h0000, pn_scale_r};
            ADDR_DECIM: s_axi_rdata <= {16'h0000, decim_r};
            ADDR_FREQ_ACT: s_axi_rdata <= freq_act_r;
            ADDR_PHASE_RD: s_axi_rdata <= phase_acc_r;
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- sync pin and frequency transfer ----------------
   // level counts only once the second and third flops agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_sh_r <= 3'h0;
         sync_lvl_r <= 1'b0;
      end else begin
         sync_sh_r <= {sync_sh_r[1:0], sync_pulse_input};
         if (sync_sh_r[1] == sync_sh_r[2]) sync_lvl_r <= sync_sh_r[2];
      end
   end
   assign sync_ev = sync_sh_r[1] && sync_sh_r[2] && !sync_lvl_r;
   assign xfer_wr = wr_go && aw_addr_r == ADDR_FREQ_XFER;
   assign load_ev = xfer_wr || (sync_ev && ctrl_r[CTRL_SYNC_EN]);
   assign accept = !input_enable_n;

   always_ff @(posedge aclk) begin
      if (!aresetn) freq_act_r <= FREQ_RST;
      else if (load_ev) freq_act_r <= freq_hold_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_acc_r <= 32'h0000_0000;
      end else if (load_ev && ctrl_r[CTRL_ZERO_EN]) begin
         phase_acc_r <= accept ? freq_hold_r : 32'h0000_0000;
      end else if (accept) begin
         phase_acc_r <= phase_acc_r + freq_act_r;
      end
   end

   // ---------------- sine/cosine by cordic ----------------
   logic [31:0] phase_sum;
   logic [PHASE_W-1:0] ph;
   logic flip;
   logic signed [CORDIC_W-1:0] cx [CORDIC_N+1];
   logic signed [CORDIC_W-1:0] cy [CORDIC_N+1];
   logic signed [PHASE_W-1:0] cz [CORDIC_N+1];
   assign phase_sum = phase_acc_r + phase_ofs_r;
   assign ph = phase_sum[31 -: PHASE_W];
   // fold quadrants two and three by half a turn; cordic converges near zero only
   assign flip = ph[23] ^ ph[22];
   assign cx[0] = CORDIC_X0;
   assign cy[0] = '0;
   assign cz[0] = flip ? {~ph[23], ph[22:0]} : ph;
   for (genvar k = 0; k < CORDIC_N; k++) begin : g_cordic
      logic up;
      assign up = !cz[k][PHASE_W-1];
      assign cx[k+1] = up ? cx[k] - (cy[k] >>> k) : cx[k] + (cy[k] >>> k);
      assign cy[k+1] = up ? cy[k] + (cx[k] >>> k) : cy[k] - (cx[k] >>> k);
      assign cz[k+1] = up ? cz[k] - ncm_atan(k) : cz[k] + ncm_atan(k);
   end
   logic signed [CORDIC_W-1:0] cos_w, sin_w;
   assign cos_w = flip ? -cx[CORDIC_N] : cx[CORDIC_N];
   assign sin_w = flip ? -cy[CORDIC_N] : cy[CORDIC_N];

   // ---------------- stage 1: sample and sinusoids ----------------
   logic signed [15:0] s1_mant_r;
   logic [3:0] s1_exp_r, s2_exp_r;
   logic signed [AMP_W-1:0] s1_cos_r, s1_sin_r;
   logic v1_r, v2_r, v3_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         v1_r <= 1'b0;
         s1_mant_r <= '0;
         s1_exp_r <= 4'h0;
         s1_cos_r <= '0;
         s1_sin_r <= '0;
      end else begin
         v1_r <= accept;
         if (accept) begin
            s1_mant_r <= in_sample.mant;
            s1_exp_r <= in_sample.expo;
            s1_cos_r <= cos_w[AMP_W-1:0];
            s1_sin_r <= sin_w[AMP_W-1:0];
         end
      end
   end

   // ---------------- stage 2: mixer and pn ----------------
   logic [22:0] lfsr_r;
   logic signed [34:0] prod_i, prod_q;
   logic signed [MIX_W-1:0] noise;
   logic signed [MIX_W-1:0] mix_i_r, mix_q_r;
   assign prod_i = s1_mant_r * s1_cos_r;
   assign prod_q = -(s1_mant_r * s1_sin_r);
   // scale sits at 2^-3..2^-18, three sign bits above; zero scale gives zero
   assign noise = lfsr_r[0] ? -$signed({3'b000, pn_scale_r, 5'b00000})
                            : $signed({3'b000, pn_scale_r, 5'b00000});

   function automatic logic signed [MIX_W-1:0] sat_add(input logic signed [MIX_W-1:0] a,
                                                       input logic signed [MIX_W-1:0] b);
      logic signed [MIX_W:0] s;
      s = a + b;
      if (s[MIX_W] != s[MIX_W-1]) return s[MIX_W] ? 24'sh800000 : 24'sh7FFFFF;
      return s[MIX_W-1:0];
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lfsr_r <= LFSR_SEED;
         v2_r <= 1'b0;
         mix_i_r <= '0;
         mix_q_r <= '0;
         s2_exp_r <= 4'h0;
      end else begin
         v2_r <= v1_r;
         if (v1_r) begin
            lfsr_r <= {lfsr_r[21:0], lfsr_r[22] ^ lfsr_r[17]};
            mix_i_r <= sat_add(prod_i[33:10], noise);
            mix_q_r <= sat_add(prod_q[33:10], noise);
            s2_exp_r <= s1_exp_r;
         end
      end
   end

   // ---------------- stage 3: barrel shifter ----------------
   logic [6:0] shift_sum, shift_amt;
   logic signed [PATH_W-1:0] wide_r [2];
   assign shift_sum = {1'b0, ctrl_r[CTRL_SHIFT_LSB +: 6]} + {3'b000, s2_exp_r};
   assign shift_amt = shift_sum > 7'(SHIFT_MAX) ? 7'(SHIFT_MAX) : shift_sum;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         v3_r <= 1'b0;
         wide_r[0] <= '0;
         wide_r[1] <= '0;
      end else begin
         v3_r <= v2_r;
         if (v2_r) begin
            // low 24 bits of the 69-bit path; overflow past the top is dropped
            wide_r[0] <= PATH_W'($signed(mix_i_r)) <<< shift_amt;
            wide_r[1] <= PATH_W'($signed(mix_q_r)) <<< shift_amt;
         end
      end
   end

   // ---------------- stage 4: integrators and decimation ----------------
   logic [2:0] order;
   logic [15:0] dcnt_r;
   logic dec_v_r;
   assign order = ctrl_r[CTRL_ORDER_LSB +: 3] > 3'(NSTG) ? 3'(NSTG) : ctrl_r[CTRL_ORDER_LSB +: 3];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dcnt_r <= 16'h0000;
         dec_v_r <= 1'b0;
      end else begin
         dec_v_r <= v3_r && dcnt_r == decim_r;
         if (v3_r) dcnt_r <= dcnt_r == decim_r ? 16'h0000 : dcnt_r + 16'h0001;
      end
   end

   // stage outputs held left aligned at full path width
   logic signed [PATH_W-1:0] so [2][NSTG+1];
   logic signed [23:0] cin [2][NSTG+1];
   logic signed [23:0] cdly_r [2][NSTG];
   for (genvar a = 0; a < 2; a++) begin : g_axis
      assign so[a][0] = wide_r[a];
      for (genvar k = 0; k < NSTG; k++) begin : g_int
         localparam int W = ncm_integ_w(k);
         logic signed [W-1:0] acc_r;
         always_ff @(posedge aclk) begin
            if (!aresetn) acc_r <= '0;
            else if (v3_r) acc_r <= acc_r + so[a][k][PATH_W-1 -: W];
         end
         if (W == PATH_W) begin : g_full
            assign so[a][k+1] = acc_r;
         end else begin : g_trunc
            assign so[a][k+1] = {acc_r, {(PATH_W-W){1'b0}}};
         end
      end
      // combs, one delay each; stages beyond the order pass through
      assign cin[a][0] = so[a][order][PATH_W-1 -: 24];
      for (genvar j = 0; j < NSTG; j++) begin : g_comb
         always_ff @(posedge aclk) begin
            if (!aresetn) cdly_r[a][j] <= '0;
            else if (dec_v_r) cdly_r[a][j] <= cin[a][j];
         end
         assign cin[a][j+1] = (3'(j) < order) ? cin[a][j] - cdly_r[a][j] : cin[a][j];
      end
   end

   // ---------------- output ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_valid <= 1'b0;
         out_data <= '0;
      end else if (ctrl_r[CTRL_BYPASS]) begin
         out_valid <= v3_r;
         if (v3_r) begin
            out_data.i <= wide_r[0][PATH_W-1 -: 24];
            out_data.q <= wide_r[1][PATH_W-1 -: 24];
         end
      end else begin
         out_valid <= dec_v_r;
         if (dec_v_r) begin
            out_data.i <= cin[0][NSTG];
            out_data.q <= cin[1][NSTG];
         end
      end
   end
endmodule
`default_nettype wire

// file: sim/ncm_stream_model.sv
// stream partner: gated sample source and decimated output collector
`timescale 1ns/100ps
`default_nettype none
module ncm_stream_model
   import ncm_pkg::*;
(
   input wire logic aclk,
   input wire logic go,
   input wire logic [7:0] count,
   input wire logic gapped,
   input wire ncm_smp_t smp,
   input wire ncm_iq_t out_data,
   input wire logic out_valid,
   output ncm_smp_t in_sample,
   output logic input_enable_n,
   output logic busy,
   output logic [15:0] n_out,
   output ncm_iq_t last_out
);
   logic [7:0] left_r = 8'h00;
   logic skip_r = 1'b0;
   logic take;
   assign busy = left_r != 8'h00;
   assign take = busy && !skip_r;
   assign input_enable_n = !take;
   // off-cycles show the inverse so a capture of an idle bus is visible
   assign in_sample = take ? smp : ~smp;
   always_ff @(posedge aclk) begin
      if (go) begin
         left_r <= count;
         skip_r <= 1'b0;
      end else if (busy) begin
         if (take) left_r <= left_r - 8'h01;
         skip_r <= gapped && !skip_r;
      end
   end
   always_ff @(posedge aclk) begin
      if (go) n_out <= 16'h0000;
      else if (out_valid) n_out <= n_out + 16'h0001;
   end
   always_ff @(posedge aclk) begin
      if (out_valid) last_out <= out_data;
   end
endmodule
`default_nettype wire

// file: sim/ncm_top_checker.sv
// assertion checker on the ncm_top ports
`timescale 1ns/100ps
`default_nettype none
module ncm_top_checker
   import ncm_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic input_enable_n,
   input wire ncm_iq_t out_data,
   input wire logic out_valid
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_wr_blocked: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_wr_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_rd_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   // bypass answers four edges after the take, the cic path five
   a_out_cause: assert property (
      out_valid |-> !$past(input_enable_n, 4) || !$past(input_enable_n, 5))
      else $error("output without an accepted sample");
   a_gate_idle: assert property (
      input_enable_n [*5] |=> !out_valid)
      else $error("output while input gated off");
   a_out_steady: assert property (
      !out_valid |-> $stable(out_data))
      else $error("output data moved without strobe");
endmodule
bind ncm_top ncm_top_checker i_ncm_top_checker (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .input_enable_n(input_enable_n), .out_data(out_data),
   .out_valid(out_valid));
`default_nettype wire

// file: sim/ncm_top_tb_top.sv
// self-checking bench for the nco, mixer, pn and cic front end
`timescale 1ns/100ps
`default_nettype none
module ncm_top_tb_top
   import ncm_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, count = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic go = 1'b0, gapped = 1'b0, sync_in = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, out_valid, busy, input_enable_n;
   logic [31:0] wdata = 32'h0, rdata, rd_d;
   logic [1:0] bresp, rresp, rd_r;
   logic [15:0] n_out;
   ncm_smp_t in_sample;
   ncm_smp_t smp = '0;
   ncm_iq_t out_data, last_out;
   int mismatches = 0, samples_checked = 0, cycles = 0;
   ncm_top i_ncm_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .in_sample(in_sample), .input_enable_n(input_enable_n), .sync_pulse_input(sync_in),
      .out_data(out_data), .out_valid(out_valid));
   ncm_stream_model i_ncm_stream_model (.aclk(aclk), .go(go), .count(count),
      .gapped(gapped), .smp(smp), .out_data(out_data), .out_valid(out_valid),
      .in_sample(in_sample), .input_enable_n(input_enable_n), .busy(busy), .n_out(n_out),
      .last_out(last_out));
   initial forever #20 aclk = !aclk;
   task automatic final_report;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // cordic amplitude is not exact, so mixer levels get a window
   task automatic chk_in(input logic signed [23:0] got, input logic signed [31:0] lo,
         input logic signed [31:0] hi);
      logic ok;
      ok = (got >= lo) && (got <= hi);
      samples_checked++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask
   function automatic logic [23:0] mag(input logic signed [23:0] v);
      return v[23] ? 24'(-v) : v;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      while (!bvalid) @(posedge aclk);
      bready <= 1'b0;
      chk(bresp, er);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      rd_d = rdata;
      rd_r = rresp;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      rd(a);
      chk(rd_d, ed);
      chk(rd_r, er);
   endtask
   task automatic run(input logic [7:0] n, input logic g);
      @(posedge aclk);
      count <= n;
      gapped <= g;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      do @(posedge aclk); while (busy);
      repeat (8) @(posedge aclk);
   endtask
   task automatic t_regs;
      for (int a = 0; a < 32; a += 4) rdc(8'(a), 32'h0, RESP_OKAY);
      rdc(8'h20, 32'h0, RESP_SLVERR);
      wr(8'h02, 32'h1, RESP_SLVERR);
      wr(ADDR_FREQ_ACT, 32'h5, RESP_OKAY);
      rdc(ADDR_FREQ_ACT, 32'h0, RESP_OKAY);
   endtask
   task automatic pulse_sync;
      sync_in <= 1'b1;
      repeat (4) @(posedge aclk);
      sync_in <= 1'b0;
      repeat (6) @(posedge aclk);
   endtask
   task automatic t_nco;
      logic [31:0] a0;
      wr(ADDR_FREQ_HOLD, 32'h0100_0000, RESP_OKAY);
      rdc(ADDR_FREQ_ACT, 32'h0, RESP_OKAY);
      wr(ADDR_FREQ_XFER, 32'h0, RESP_OKAY);
      rdc(ADDR_FREQ_ACT, 32'h0100_0000, RESP_OKAY);
      rd(ADDR_PHASE_RD);
      a0 = rd_d;
      run(8'h05, 1'b1);
      rdc(ADDR_PHASE_RD, a0 + 32'h0500_0000, RESP_OKAY);
      wr(ADDR_FREQ_HOLD, 32'h1234_5678, RESP_OKAY);
      // sync transfer still disabled: the pulse must leave the active word alone
      pulse_sync();
      rdc(ADDR_FREQ_ACT, 32'h0100_0000, RESP_OKAY);
      wr(ADDR_CTRL, 32'h30, RESP_OKAY);
      pulse_sync();
      rdc(ADDR_FREQ_ACT, 32'h1234_5678, RESP_OKAY);
      rdc(ADDR_PHASE_RD, 32'h0, RESP_OKAY);
      wr(ADDR_FREQ_HOLD, 32'h0, RESP_OKAY);
      wr(ADDR_FREQ_XFER, 32'h0, RESP_OKAY);
      rdc(ADDR_FREQ_ACT, 32'h0, RESP_OKAY);
   endtask
   task automatic t_mix;
      smp <= {16'h4000, 4'h0};
      wr(ADDR_CTRL, 32'h02D0_8000, RESP_OKAY);
      rdc(ADDR_CTRL, 32'h02D0_8000, RESP_OKAY);
      run(8'h08, 1'b0);
      chk_in(last_out.i, 32'sh3F8000, 32'sh400000);
      chk_in(last_out.q, -32'sh200, 32'sh200);
      wr(ADDR_PHASE_OFS, 32'h4000_0000, RESP_OKAY);
      run(8'h08, 1'b0);
      chk_in(last_out.i, -32'sh200, 32'sh200);
      chk_in(last_out.q, -32'sh400000, -32'sh3F8000);
      wr(ADDR_PHASE_OFS, 32'h0, RESP_OKAY);
   endtask
   task automatic t_pn;
      logic [15:0] sc [3] = '{16'h0000, 16'h0001, 16'hFFFF};
      smp <= {16'h0000, 4'h0};
      foreach (sc[k]) begin
         wr(ADDR_PN_SCALE, {16'h0, sc[k]}, RESP_OKAY);
         run(8'h06, 1'b1);
         chk(mag(last_out.i), {3'h0, sc[k], 5'h0});
         chk(mag(last_out.q), {3'h0, sc[k], 5'h0});
      end
   endtask
   task automatic shf(input logic [5:0] code, input logic [3:0] ex, input logic [15:0] sc,
         input logic [23:0] m);
      smp <= {16'h0000, ex};
      wr(ADDR_CTRL, {6'h00, code, 20'h08000}, RESP_OKAY);
      wr(ADDR_PN_SCALE, {16'h0, sc}, RESP_OKAY);
      run(8'h06, 1'b1);
      chk(mag(last_out.i), m);
   endtask
   task automatic cic(input logic [2:0] ord, input logic [15:0] dec, input logic [5:0] sh,
         input logic byp, input logic [15:0] cnt);
      wr(ADDR_DECIM, {16'h0, dec}, RESP_OKAY);
      wr(ADDR_CTRL, {6'h00, sh, 4'h0, byp, 12'h000, ord}, RESP_OKAY);
      run(8'h30, 1'b1);
      chk(n_out, cnt);
      chk_in(last_out.i, 32'sh3F0000, 32'sh400000);
   endtask
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_nco();
      t_mix();
      t_pn();
      shf(6'h28, 4'h0, 16'h0001, 24'h000001);
      shf(6'h2C, 4'h0, 16'h0001, 24'h000010);
      shf(6'h28, 4'h5, 16'h0001, 24'h000020);
      shf(6'h2F, 4'h5, 16'h8000, 24'h400000);
      smp <= {16'h4000, 4'h0};
      wr(ADDR_PN_SCALE, 32'h0, RESP_OKAY);
      // shift chosen so that shifter and cic gain multiply to one
      for (int n = 0; n < 6; n++) begin
         cic(3'(n), 16'h0001, 6'(6'h2D - 6'(n)), 1'b0, 16'h0018);
      end
      cic(3'h2, 16'h0003, 6'h29, 1'b0, 16'h000C);
      cic(3'h5, 16'h0003, 6'h2D, 1'b1, 16'h0030);
      final_report();
   end
endmodule
`default_nettype wire
